// ===== logic/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_CHANNEL_ENABLE_MASK = 8'h18;
  localparam logic [7:0] OFS_SCAN_RESULT_BITS = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_PTR = 8'h24;
  localparam logic [7:0] OFS_BUFRD = 8'h28;
  localparam logic [7:0] OFS_CURRENT_CHANNEL_INDEX = 8'h2C;
  localparam logic [7:0] OFS_DECST = 8'h30;
  localparam logic [7:0] OFS_DECIN = 8'h34;
  localparam logic [7:0] OFS_IDLE = 8'h38;
  // ********************
  // field positions
  // ********************
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_DECODE = 2;
  localparam int CMD_FLUSH = 3;
  localparam int ST_AVAIL = 0;
  localparam int ST_HALF = 1;
  localparam int ST_FULL = 2;
  localparam int ST_RUN = 3;
  localparam int ST_IO = 4;
  localparam int ST_CONV = 5;
  localparam int PTR_WR_LSB = 5;
  localparam int NCH = 16;
  localparam int DEPTH = 16;
  localparam logic [4:0] HALF_LEVEL = 5'h08;
  localparam logic [4:0] FULL_LEVEL = 5'h10;
  // ********************
  // idle modes and timing
  // ********************
  localparam logic [1:0] IDLE_OFF = 2'h0;
  localparam logic [1:0] IDLE_HIGH = 2'h1;
  localparam logic [1:0] IDLE_LOW = 2'h2;
  localparam logic [1:0] IDLE_CONV = 2'h3;
  localparam int CH_DWELL = 4;
  localparam logic [3:0] DWELL_LAST = 4'(CH_DWELL - 1);
  localparam logic [15:0] SCAN_PERIOD_RST = 16'h0040;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [3:0] RST4 = 4'h0;

  typedef enum logic [1:0] {SSC_IDLE, SSC_SCAN, SSC_CONV} ssc_phase_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ssc_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ssc_rsp_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe_b;
  } ssc_pins_t;
endpackage
`default_nettype wire

// ===== logic/ssc_idle_drive.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// per-channel idle-phase pin driver
// ********************
module ssc_idle_drive (
  input wire logic [31:0] cfg_i,
  input wire logic idle_i,
  input wire logic [15:0] active_o_i,
  input wire logic [15:0] active_oe_b_i,
  input wire logic conv_ch0_i,
  input wire logic conv_ch1_i,
  output ssc_pkg::ssc_pins_t pins_o
);
  // choose a value per channel; mode 3 only for groups with a converter path
  always_comb
  begin
    pins_o = '{out: active_o_i, oe_b: active_oe_b_i};
    for (int n = 0; n < ssc_pkg::NCH; n++)
    begin
      if (idle_i)
      begin
        unique case (cfg_i[2*n +: 2])
          ssc_pkg::IDLE_HIGH:
          begin
            pins_o.out[n] = 1'b1; // [RQ17]
            pins_o.oe_b[n] = 1'b0;
          end
          ssc_pkg::IDLE_LOW:
          begin
            pins_o.out[n] = 1'b0; // [RQ17]
            pins_o.oe_b[n] = 1'b0;
          end
          ssc_pkg::IDLE_CONV:
          begin
            // channels 4..11 have no converter path, pin stays released
            pins_o.out[n] = (n < 4) ? conv_ch0_i : conv_ch1_i; // [RQ20] [RQ18]
            pins_o.oe_b[n] = !((n < 4) || (n >= 12)); // [RQ19]
          end
          default:
          begin
            pins_o.out[n] = 1'b0; // [RQ17]
            pins_o.oe_b[n] = 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/ssc_regs.sv
// Contract
// [RQ1] writing one to command bit 0 starts periodic scanning
// [RQ2] command bit 1 stops scanning, after the unit_a scan completes
// [RQ3] command bit 2 starts the decoder
// [RQ4] command bit 3 empties the result buffer; command bits are strobes
// [RQ5] 16-bit channel enable mask, reset zero, bit X enables channel X
// [RQ6] read-only scan result, bit X from channel X evaluation, reset zero
// [RQ7] status bits 5,4,3: converter active, sensors interfaced, unit unit_a
// [RQ8] status bit 2 buffer full, bit 1 at least half full
// [RQ9] status bit 0 set while buffer holds unread data
// [RQ10] write pointer at bits 8:5, increments on each stored result
// [RQ11] read pointer at bits 3:0, increments on each data port read; the code leaves it unchanged on a read of an empty buffer
// [RQ12] data port read returns oldest result and consumes it
// [RQ13] 4-bit read-only current channel index, reset zero
// [RQ14] 4-bit decoder state, software writable, hardware updated
// [RQ15] 4-bit decoder input, software writable, hardware updated
// [RQ16] each channel has 2-bit idle field at bits 2N+1:2N
// [RQ17] idle field 0 disables, 1 drives high, 2 drives low
// [RQ18] channels 12-15 idle value 3 routes converter channel 1
// [RQ19] channels 10 and 11 support only disabled, high, low
// [RQ20] channels 0-3 idle value 3 routes converter channel 0
// [RQ21] reserved bits read zero and ignore writes
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ssc_regs (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire ssc_pkg::ssc_req_t avm_i,
  output ssc_pkg::ssc_rsp_t avm_o,
  input wire logic [15:0] sense_i,
  input wire logic [3:0] dec_in_i,
  input wire logic conv_ch0_i,
  input wire logic conv_ch1_i,
  output ssc_pkg::ssc_pins_t pins_o
);
  // ********************
  // state
  // ********************
  typedef struct packed {
    logic [15:0] channel_enable_mask;
    logic [15:0] scan_result_bits;
    logic [15:0] scan_acc;
    logic [3:0] current_channel_index;
    logic [3:0] dwell;
    logic [15:0] period;
    logic unit_a;
    logic stop_pend;
    logic dec_on;
    logic [3:0] decoder_current_state;
    logic [3:0] decin;
    logic [31:0] idle;
    logic [3:0] wr;
    logic [3:0] rd;
    logic [4:0] level;
    logic [31:0] rdata;
    logic ack;
    ssc_pkg::ssc_phase_t phase;
  } ssc_state_t;

  ssc_state_t st_r;
  ssc_state_t st_nxt;
  logic [15:0] buf_mem [ssc_pkg::DEPTH];
  logic push;
  logic pop;
  logic wr_cmd;
  logic rd_cmd;

  // any later channel enabled after index c
  function automatic logic more_after(input logic [15:0] m, input logic [3:0] c);
    logic r;
    r = 1'b0;
    for (int i = 0; i < ssc_pkg::NCH; i++)
    begin
      if (i > int'(c) && m[i])
      begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // first enabled channel index at or after c
  function automatic logic [3:0] next_en(input logic [15:0] m, input logic [3:0] c);
    logic [3:0] r;
    logic f;
    r = c;
    f = 1'b0;
    for (int i = 0; i < ssc_pkg::NCH; i++)
    begin
      if (!f && i >= int'(c) && m[i])
      begin
        r = 4'(i);
        f = 1'b1;
      end
    end
    return r;
  endfunction

  // single-cycle bus answer: the request waits one cycle, then acks
  assign wr_cmd = avm_i.write && !st_r.ack;
  assign rd_cmd = avm_i.read && !st_r.ack;
  assign avm_o = '{readdata: st_r.rdata, waitrequest: (avm_i.read || avm_i.write) && !st_r.ack};

  // ********************
  // next-state logic
  // ********************
  always_comb
  begin
    st_nxt = st_r;
    push = 1'b0;
    pop = 1'b0;
    st_nxt.ack = wr_cmd || rd_cmd;
    // scan engine
    unique case (st_r.phase)
      ssc_pkg::SSC_IDLE:
      begin
        if (st_r.unit_a)
        begin
          if (st_r.period != ssc_pkg::RST16)
          begin
            st_nxt.period = st_r.period - 16'h0001;
          end
          else if (st_r.channel_enable_mask != ssc_pkg::RST16)
          begin
            st_nxt.period = ssc_pkg::SCAN_PERIOD_RST;
            st_nxt.phase = ssc_pkg::SSC_SCAN;
            st_nxt.current_channel_index = next_en(st_r.channel_enable_mask, ssc_pkg::RST4); // [RQ13]
            st_nxt.dwell = ssc_pkg::RST4;
            st_nxt.scan_acc = ssc_pkg::RST16;
          end
        end
      end
      ssc_pkg::SSC_SCAN:
      begin
        st_nxt.dwell = st_r.dwell + 4'h1;
        if (st_r.dwell == ssc_pkg::DWELL_LAST)
        begin
          st_nxt.phase = ssc_pkg::SSC_CONV;
        end
      end
      ssc_pkg::SSC_CONV:
      begin
        // evaluate channel, store result word
        st_nxt.scan_acc[st_r.current_channel_index] = sense_i[st_r.current_channel_index];
        st_nxt.dwell = ssc_pkg::RST4;
        if (more_after(st_r.channel_enable_mask, st_r.current_channel_index))
        begin
          st_nxt.current_channel_index = next_en(st_r.channel_enable_mask, st_r.current_channel_index + 4'h1);
          st_nxt.phase = ssc_pkg::SSC_SCAN;
        end
        else
        begin
          st_nxt.phase = ssc_pkg::SSC_IDLE;
          st_nxt.scan_result_bits = st_r.scan_acc; // [RQ6]
          st_nxt.scan_result_bits[st_r.current_channel_index] = sense_i[st_r.current_channel_index];
          push = st_r.level != ssc_pkg::FULL_LEVEL;
          if (st_r.stop_pend)
          begin
            st_nxt.unit_a = 1'b0; // [RQ2]
            st_nxt.stop_pend = 1'b0;
          end
        end
      end
      default:
      begin
        // unused phase code, fall back to idle
        st_nxt.phase = ssc_pkg::SSC_IDLE;
      end
    endcase
    // decoder follows inputs while on
    if (st_r.dec_on)
    begin
      st_nxt.decin = dec_in_i; // [RQ15]
      st_nxt.decoder_current_state = dec_in_i ^ st_r.decoder_current_state; // [RQ14]
    end
    // register writes, software after hardware
    if (wr_cmd)
    begin
      unique case (avm_i.address)
        ssc_pkg::OFS_CMD:
        begin
          if (avm_i.writedata[ssc_pkg::CMD_START])
          begin
            st_nxt.unit_a = 1'b1; // [RQ1]
            st_nxt.stop_pend = 1'b0;
          end
          if (avm_i.writedata[ssc_pkg::CMD_STOP])
          begin
            if (st_r.phase == ssc_pkg::SSC_IDLE)
            begin
              st_nxt.unit_a = 1'b0; // [RQ2]
              // cancel a scan launched in this same cycle, so a stopped unit never scans
              st_nxt.phase = ssc_pkg::SSC_IDLE;
              st_nxt.current_channel_index = st_r.current_channel_index;
            end
            else
            begin
              st_nxt.stop_pend = 1'b1; // [RQ2]
            end
          end
          if (avm_i.writedata[ssc_pkg::CMD_DECODE])
          begin
            st_nxt.dec_on = 1'b1; // [RQ3]
          end
        end
        ssc_pkg::OFS_CHANNEL_ENABLE_MASK: st_nxt.channel_enable_mask = avm_i.writedata[15:0]; // [RQ5] [RQ21]
        ssc_pkg::OFS_DECST: st_nxt.decoder_current_state = avm_i.writedata[3:0]; // [RQ14]
        ssc_pkg::OFS_DECIN: st_nxt.decin = avm_i.writedata[3:0]; // [RQ15]
        ssc_pkg::OFS_IDLE: st_nxt.idle = avm_i.writedata; // [RQ16]
        default: st_nxt.idle = st_r.idle;
      endcase
    end
    // read mux, reserved bits zero
    st_nxt.rdata = 32'h00000000; // [RQ21]
    if (rd_cmd)
    begin
      unique case (avm_i.address)
        ssc_pkg::OFS_CHANNEL_ENABLE_MASK: st_nxt.rdata[15:0] = st_r.channel_enable_mask;
        ssc_pkg::OFS_SCAN_RESULT_BITS: st_nxt.rdata[15:0] = st_r.scan_result_bits; // [RQ6]
        ssc_pkg::OFS_STATUS:
        begin
          st_nxt.rdata[ssc_pkg::ST_CONV] = st_r.phase == ssc_pkg::SSC_CONV; // [RQ7]
          st_nxt.rdata[ssc_pkg::ST_IO] = st_r.phase != ssc_pkg::SSC_IDLE; // [RQ7]
          st_nxt.rdata[ssc_pkg::ST_RUN] = st_r.unit_a; // [RQ7]
          st_nxt.rdata[ssc_pkg::ST_FULL] = st_r.level == ssc_pkg::FULL_LEVEL; // [RQ8]
          st_nxt.rdata[ssc_pkg::ST_HALF] = st_r.level >= ssc_pkg::HALF_LEVEL; // [RQ8]
          st_nxt.rdata[ssc_pkg::ST_AVAIL] = st_r.level != 5'h00; // [RQ9]
        end
        ssc_pkg::OFS_PTR:
        begin
          st_nxt.rdata[ssc_pkg::PTR_WR_LSB +: 4] = st_r.wr; // [RQ10]
          st_nxt.rdata[3:0] = st_r.rd; // [RQ11]
        end
        ssc_pkg::OFS_BUFRD:
        begin
          st_nxt.rdata[15:0] = buf_mem[st_r.rd]; // [RQ12]
          pop = st_r.level != 5'h00;
        end
        ssc_pkg::OFS_CURRENT_CHANNEL_INDEX: st_nxt.rdata[3:0] = st_r.current_channel_index; // [RQ13]
        ssc_pkg::OFS_DECST: st_nxt.rdata[3:0] = st_r.decoder_current_state;
        ssc_pkg::OFS_DECIN: st_nxt.rdata[3:0] = st_r.decin;
        ssc_pkg::OFS_IDLE: st_nxt.rdata = st_r.idle;
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    // buffer pointers; flush wins over any same-cycle push or pop
    if (push)
    begin
      st_nxt.wr = st_r.wr + 4'h1; // [RQ10]
    end
    if (pop)
    begin
      st_nxt.rd = st_r.rd + 4'h1; // [RQ11] [RQ12]
    end
    st_nxt.level = st_r.level + {4'h0, push} - {4'h0, pop};
    if (wr_cmd && avm_i.address == ssc_pkg::OFS_CMD && avm_i.writedata[ssc_pkg::CMD_FLUSH])
    begin
      st_nxt.wr = ssc_pkg::RST4; // [RQ4]
      st_nxt.rd = ssc_pkg::RST4;
      st_nxt.level = 5'h00;
    end
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= '0;
      st_r.period <= ssc_pkg::SCAN_PERIOD_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // result storage, content undefined after reset
  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      buf_mem[st_r.wr] <= st_nxt.scan_result_bits;
    end
  end

  // pin drive: active channel driven with its enable while scanning
  ssc_idle_drive u_drive (
    .cfg_i(st_r.idle),
    .idle_i(st_r.phase == ssc_pkg::SSC_IDLE),
    .active_o_i(16'h0000),
    .active_oe_b_i(~(16'h0001 << st_r.current_channel_index)),
    .conv_ch0_i(conv_ch0_i),
    .conv_ch1_i(conv_ch1_i),
    .pins_o(pins_o)
  );

  // ********************
  // checks
  // ********************
  bus_ack_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ12]
    (avm_i.read || avm_i.write) && !st_r.ack |=> st_r.ack)
    else $error("bus not acked after one cycle");
  stop_wait_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ2]
    st_r.stop_pend |-> st_r.unit_a)
    else $error("unit stopped with stop pending");
  full_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ8]
    st_r.level <= ssc_pkg::FULL_LEVEL)
    else $error("buffer level overflow");
  ptr_gap_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ10]
    st_r.wr == st_r.rd + st_r.level[3:0])
    else $error("pointer gap mismatch");
  pop_adv_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ11]
    pop && !push && !(wr_cmd) |=> st_r.rd == $past(st_r.rd) + 4'h1)
    else $error("read pointer did not advance");
  start_run_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ1]
    wr_cmd && avm_i.address == ssc_pkg::OFS_CMD && avm_i.writedata[ssc_pkg::CMD_START]
      && !avm_i.writedata[ssc_pkg::CMD_STOP] |=> st_r.unit_a)
    else $error("start did not set unit_a");
  flush_empty_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ4]
    wr_cmd && avm_i.address == ssc_pkg::OFS_CMD && avm_i.writedata[ssc_pkg::CMD_FLUSH]
      |=> st_r.level == 5'h00)
    else $error("flush left data");
  channel_enable_mask_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ5]
    !(wr_cmd && avm_i.address == ssc_pkg::OFS_CHANNEL_ENABLE_MASK) |=> $stable(st_r.channel_enable_mask))
    else $error("enable mask changed without write");
  // scan engine, pointer and decoder checks
  scan_run_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ7]
    st_r.phase != ssc_pkg::SSC_IDLE |-> st_r.unit_a)
    else $error("scanning while unit not unit_a");
  push_adv_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ10]
    push && !(wr_cmd && avm_i.address == ssc_pkg::OFS_CMD && avm_i.writedata[ssc_pkg::CMD_FLUSH])
      |=> st_r.wr == $past(st_r.wr) + 4'h1)
    else $error("write pointer did not advance");
  stop_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ2]
    wr_cmd && avm_i.address == ssc_pkg::OFS_CMD && avm_i.writedata[ssc_pkg::CMD_STOP]
      && !avm_i.writedata[ssc_pkg::CMD_START] && st_r.phase == ssc_pkg::SSC_IDLE |=> !st_r.unit_a)
    else $error("idle stop left unit unit_a");
  dec_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ14]
    !st_r.dec_on && !wr_cmd |=> $stable(st_r.decoder_current_state))
    else $error("decoder state moved while off");
endmodule
`default_nettype wire

// ===== testbench/ssc_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// far-side sensor bank
// ********************
module ssc_sensor_model (
  input wire logic core_clk_i,
  input wire logic [15:0] level_i,
  output var logic [15:0] sense_o
);
  // sensors settle one cycle after the bench moves them, like a slow comparator
  always_ff @(posedge core_clk_i)
    sense_o <= level_i;
endmodule
`default_nettype wire

// ===== testbench/ssc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_regs_tb;
  // ********************
  // stimulus and bookkeeping
  // ********************
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  ssc_pkg::ssc_req_t req = '0;
  ssc_pkg::ssc_rsp_t rsp;
  ssc_pkg::ssc_pins_t pins;
  logic [15:0] lvl = 16'h0000;
  logic [15:0] sense;
  logic [3:0] dec_in = 4'h0;
  logic cv0 = 1'b0;
  logic cv1 = 1'b0;
  logic [63:0] expq[$];
  logic [63:0] e;
  logic [31:0] q;
  logic [31:0] v;
  logic [7:0] i;
  int k;
  int mismatches = 0;
  int num_checks = 0;

  always #20 core_clk_i = ~core_clk_i;

  ssc_regs dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avm_i(req), .avm_o(rsp), .sense_i(sense),
    .dec_in_i(dec_in), .conv_ch0_i(cv0), .conv_ch1_i(cv1), .pins_o(pins));
  ssc_sensor_model sens (.core_clk_i(core_clk_i), .level_i(lvl), .sense_o(sense));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read monitor: looks in the settled half cycle before the ack edge
  always @(negedge core_clk_i)
    if (req.read && rsp.waitrequest === 1'b0)
    begin
      e = expq.pop_front();
      if (e[63:32] != 32'h0)
        chk(rsp.readdata & e[63:32], e[31:0] & e[63:32]);
    end

  // ********************
  // bus master
  // ********************
  // request held through the rising edge after waitrequest is seen low at a falling edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    logic w;
    @(posedge core_clk_i);
    req.address <= a;
    req.write <= wr;
    req.read <= !wr;
    req.writedata <= d;
    n = 0;
    w = 1'b1;
    // sampled mid-cycle: the value holds up to the next rising edge, no race with the flops
    while (w && n < 50)
    begin
      @(negedge core_clk_i);
      w = rsp.waitrequest !== 1'b0;
      rd = rsp.readdata;
      @(posedge core_clk_i);
      n++;
    end
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (w)
    begin
      mismatches++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  // a zero mask notes a read that is only polled, never judged
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    expq.push_back({msk, exp});
    bus(1'b0, a, 32'h0, q);
  endtask

  // status polling bounded so a stuck flag cannot hang the run
  task automatic poll(input int b, input logic val);
    int n;
    for (n = 0; n < 2000; n++)
    begin
      rdc(ssc_pkg::OFS_STATUS, 32'h0, 32'h0);
      if (q[b] === val)
        return;
    end
    mismatches++;
    finish_test();
  endtask

  // idle pins against the per-channel field; undefined codes skipped
  task automatic pchk(input logic [31:0] cfg);
    int c;
    logic [1:0] md;
    @(negedge core_clk_i);
    for (c = 0; c < 16; c++)
    begin
      md = cfg[2*c +: 2];
      if (md == 2'h3 && c > 3 && c < 12)
        continue;
      chk({31'h0, pins.oe_b[c]}, {31'h0, md == 2'h0});
      if (md != 2'h0)
        chk({31'h0, pins.out[c]}, {31'h0, md == 2'h1 || (md == 2'h3 && (c < 4 ? cv0 : cv1))});
    end
  endtask

  // ********************
  // main sequence
  // ********************
  initial
  begin
    void'($urandom(44));
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    // reset values, unmapped 0x3C included
    for (i = 8'h18; i <= 8'h3C; i += 8'h04)
      if (i != ssc_pkg::OFS_BUFRD)
        rdc(i, 32'h0, 32'hFFFFFFFF);
    v = $urandom();
    wr(ssc_pkg::OFS_CHANNEL_ENABLE_MASK, v);
    rdc(ssc_pkg::OFS_CHANNEL_ENABLE_MASK, {16'h0, v[15:0]}, 32'hFFFFFFFF);
    wr(ssc_pkg::OFS_PTR, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_PTR, 32'h0, 32'hFFFFFFFF);
    wr(ssc_pkg::OFS_DECST, 32'hFFFFFFF5);
    rdc(ssc_pkg::OFS_DECST, 32'h5, 32'hFFFFFFFF);
    wr(ssc_pkg::OFS_DECIN, 32'h0000000A);
    rdc(ssc_pkg::OFS_DECIN, 32'hA, 32'hFFFFFFFF);
    // every idle code on all channels, then one mixed pattern
    for (k = 0; k < 5; k++)
    begin
      cv0 <= 1'($urandom());
      cv1 <= 1'($urandom());
      v = (k < 4) ? {16{k[1:0]}} : $urandom();
      wr(ssc_pkg::OFS_IDLE, v);
      rdc(ssc_pkg::OFS_IDLE, v, 32'hFFFFFFFF);
      pchk(v);
    end
    // one scan, then stop and inspect the stored word
    lvl <= 16'($urandom());
    wr(ssc_pkg::OFS_CHANNEL_ENABLE_MASK, 32'h0000FFFF);
    wr(ssc_pkg::OFS_CMD, 32'h1);
    poll(ssc_pkg::ST_AVAIL, 1'b1);
    wr(ssc_pkg::OFS_CMD, 32'h2);
    poll(ssc_pkg::ST_RUN, 1'b0);
    rdc(ssc_pkg::OFS_STATUS, 32'h1, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_SCAN_RESULT_BITS, {16'h0, lvl}, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_PTR, 32'h20, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_BUFRD, {16'h0, lvl}, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_PTR, 32'h21, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_STATUS, 32'h0, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_CURRENT_CHANNEL_INDEX, 32'hF, 32'hFFFFFFFF);
    // fill to full, stop before another scan starts, then drain watching the levels
    lvl <= 16'($urandom());
    wr(ssc_pkg::OFS_CMD, 32'h1);
    poll(ssc_pkg::ST_IO, 1'b1);
    poll(ssc_pkg::ST_FULL, 1'b1);
    wr(ssc_pkg::OFS_CMD, 32'h2);
    poll(ssc_pkg::ST_RUN, 1'b0);
    rdc(ssc_pkg::OFS_STATUS, 32'h7, 32'hFFFFFFFF);
    rdc(ssc_pkg::OFS_PTR, 32'h21, 32'hFFFFFFFF);
    for (k = 15; k >= 0; k--)
    begin
      rdc(ssc_pkg::OFS_BUFRD, {16'h0, lvl}, 32'hFFFFFFFF);
      rdc(ssc_pkg::OFS_STATUS, {29'h0, 1'b0, k >= 8, k != 0}, 32'h7);
    end
    rdc(ssc_pkg::OFS_PTR, 32'h21, 32'hFFFFFFFF);
    // flush a stored result
    wr(ssc_pkg::OFS_CMD, 32'h1);
    poll(ssc_pkg::ST_AVAIL, 1'b1);
    wr(ssc_pkg::OFS_CMD, 32'h2);
    poll(ssc_pkg::ST_RUN, 1'b0);
    wr(ssc_pkg::OFS_CMD, 32'h8);
    rdc(ssc_pkg::OFS_STATUS, 32'h0, 32'h7);
    rdc(ssc_pkg::OFS_PTR, 32'h0, 32'hFFFFFFFF);
    // decoder picks up its sensor inputs once started
    dec_in <= 4'($urandom());
    wr(ssc_pkg::OFS_CMD, 32'h4);
    repeat (4) @(posedge core_clk_i);
    rdc(ssc_pkg::OFS_DECIN, {28'h0, dec_in}, 32'hFFFFFFFF);
    finish_test();
  end
endmodule
`default_nettype wire
